// ==== src/lmisl_pkg.sv ====
// package for the two-wire slave write port: constants, states, carried words
// assumes one logic clock and a bus master that owns the serial clock
package lmisl_pkg;

    // ************************************************************
    // slave address and byte framing
    // ************************************************************
    localparam logic [4:0] SLAVE_ADDR_HI = 5'h1D;
    localparam logic [3:0] LAST_DATA_BIT = 4'h7;
    localparam logic [3:0] ACK_SLOT = 4'h8;
    localparam logic DIR_WRITE = 1'h0;
    localparam logic DIR_READ = 1'h1;

    // ************************************************************
    // strap pin decoding results
    // ************************************************************
    localparam logic [1:0] STRAP_GND = 2'h0;
    localparam logic [1:0] STRAP_SCL = 2'h1;
    localparam logic [1:0] STRAP_SDA = 2'h2;
    localparam logic [1:0] STRAP_VCC = 2'h3;

    // ************************************************************
    // protocol states, gray along idle-addr-reg-data
    // ************************************************************
    typedef enum logic [2:0] {
        LMISL_IDLE = 3'h0,
        LMISL_ADDR = 3'h1,
        LMISL_REG = 3'h3,
        LMISL_DATA = 3'h2,
        LMISL_RDAT = 3'h6,
        LMISL_IGNORE = 3'h4
    } lmisl_state_e;

    // ************************************************************
    // one register write handed to the register file
    // ************************************************************
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] data;
    } lmisl_wr_s;

endpackage

// ==== src/lmisl_slave.sv ====
// two-wire slave port of the matrix driver: address match, register pointer,
// acknowledge, write stream out through a two-entry buffer, read stream in
// assumes the master is the only clock driver and the pins are open drain
`timescale 1ns/1ns
`default_nettype none

// Function
// - answer only to the 7-bit address whose upper five bits are 11101 and low two bits are the strap.
// - the bit after the address selects direction, 0 for write and 1 for read.
// - strap tied to ground gives 00, supply 11, clock line 01 and data line 10.
// - data is taken while the clock is stably high and the idle data line rests high.
// - data falling while clock is high is a start and begins the address compare.
// - when the address matches the device pulls data low through the acknowledge slot after bit eight.
// - the register-address byte is acknowledged and loaded into the register pointer.
// - each data byte arrives most significant bit first and is acknowledged while the write buffer has room.
// - data rising while clock is high is a stop and returns the port to idle.
// - the register pointer advances by one at each data byte acknowledge.
// - the clock line is input only and the device only pulls data low or releases it.
// - after a repeated start with direction 1 the device returns the selected register.
module lmisl_slave
(
    input wire logic i_mclk,
    input wire logic i_rst_n,
    input wire logic i_scl_clk,
    input wire logic i_sda,
    output logic o_sda_out,
    output logic o_sda_oe,
    input wire logic i_strap,
    output logic o_wr_valid,
    output lmisl_pkg::lmisl_wr_s o_wr,
    input wire logic i_wr_ready,
    output logic [7:0] o_rd_addr,
    input wire logic [7:0] i_rd_data,
    output logic o_busy
);
    import lmisl_pkg::*;

    // ************************************************************
    // decoding helpers
    // ************************************************************
    // idle, start and first-low samples of the strap pin name its tie
    function automatic logic [1:0] strap_decode(input logic idle_lvl, input logic start_lvl,
                                                input logic low_lvl);
        logic [1:0] res;
        res = STRAP_GND;
        if (start_lvl && low_lvl)
        begin
            res = STRAP_VCC;
        end
        else if (start_lvl)
        begin
            res = STRAP_SCL;
        end
        else if (idle_lvl)
        begin
            res = STRAP_SDA;
        end
        return res;
    endfunction

    // ************************************************************
    // link domain: bit capture at the master's clock
    // ************************************************************
    logic frame_clr_r;
    logic link_rst_n;
    logic [3:0] lk_cnt_r;
    logic [6:0] lk_sh_r;
    logic [7:0] lk_byte_r;
    logic lk_tog_r;

    // start or stop clears the bit counter while the clock line is idle or low,
    // so the release never lands near a rising clock edge
    assign link_rst_n = i_rst_n & ~frame_clr_r;

    always_ff @(posedge i_scl_clk or negedge link_rst_n)
    begin
        if (!link_rst_n)
        begin
            lk_cnt_r <= 4'h0;
            lk_sh_r <= 7'h00;
        end
        else if (lk_cnt_r == ACK_SLOT)
        begin
            lk_cnt_r <= 4'h0;
        end
        else
        begin
            lk_cnt_r <= lk_cnt_r + 4'h1;
            lk_sh_r <= {lk_sh_r[5:0], i_sda};
        end
    end

    // the held byte stays put for nine clock periods until the next capture, ample for the crossing
    always_ff @(posedge i_scl_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            lk_byte_r <= 8'h00;
            lk_tog_r <= 1'h0;
        end
        else if (lk_cnt_r == LAST_DATA_BIT)
        begin
            lk_byte_r <= {lk_sh_r, i_sda};
            lk_tog_r <= ~lk_tog_r;
        end
    end

    // ************************************************************
    // pin synchronisers and bus conditions
    // ************************************************************
    logic scl_m_r, scl_s_r, scl_d_r;
    logic sda_m_r, sda_s_r, sda_d_r;
    logic ad_m_r, ad_s_r;
    logic tog_m_r, tog_s_r, tog_d_r;
    logic start_ev, stop_ev, fall_ev, rise_ev, byte_ev;

    // sync depth leaves the slow clock many logic cycles per phase
    always_ff @(posedge i_mclk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            {scl_m_r, scl_s_r, scl_d_r} <= 3'h7;
            {sda_m_r, sda_s_r, sda_d_r} <= 3'h7;
            {ad_m_r, ad_s_r} <= 2'h0;
            {tog_m_r, tog_s_r, tog_d_r} <= 3'h0;
        end
        else
        begin
            {scl_m_r, scl_s_r, scl_d_r} <= {i_scl_clk, scl_m_r, scl_s_r};
            {sda_m_r, sda_s_r, sda_d_r} <= {i_sda, sda_m_r, sda_s_r};
            {ad_m_r, ad_s_r} <= {i_strap, ad_m_r};
            {tog_m_r, tog_s_r, tog_d_r} <= {lk_tog_r, tog_m_r, tog_s_r};
        end
    end

    assign start_ev = scl_s_r & scl_d_r & sda_d_r & ~sda_s_r;
    assign stop_ev = scl_s_r & scl_d_r & ~sda_d_r & sda_s_r;
    assign fall_ev = scl_d_r & ~scl_s_r;
    assign rise_ev = ~scl_d_r & scl_s_r;
    assign byte_ev = tog_s_r ^ tog_d_r;

    // ************************************************************
    // strap capture
    // ************************************************************
    lmisl_state_e state_r;
    logic ad_idle_r, ad_start_r, ad_low_r;

    always_ff @(posedge i_mclk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            ad_idle_r <= 1'h0;
            ad_start_r <= 1'h0;
            ad_low_r <= 1'h0;
        end
        else
        begin
            if (state_r == LMISL_IDLE && scl_s_r && sda_s_r)
            begin
                ad_idle_r <= ad_s_r;
            end
            if (start_ev)
            begin
                ad_start_r <= ad_s_r;
            end
            if (fall_ev && frame_clr_r)
            begin
                ad_low_r <= ad_s_r;
            end
        end
    end

    // ************************************************************
    // frame clear toward the link domain
    // ************************************************************
    always_ff @(posedge i_mclk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            frame_clr_r <= 1'h1;
        end
        else if (start_ev || stop_ev)
        begin
            frame_clr_r <= 1'h1;
        end
        else if (fall_ev && state_r != LMISL_IDLE)
        begin
            frame_clr_r <= 1'h0;
        end
    end

    // ************************************************************
    // protocol state, register pointer, acknowledge decision
    // ************************************************************
    logic ack_pend_r;
    logic [3:0] rbit_r;
    logic push_ready;
    logic push_valid;
    logic addr_match;
    logic rd_acked;
    logic rd_nacked;

    assign addr_match = lk_byte_r[7:1] == {SLAVE_ADDR_HI,
                        strap_decode(ad_idle_r, ad_start_r, ad_low_r)};
    assign rd_acked = rise_ev && state_r == LMISL_RDAT && rbit_r == ACK_SLOT && !sda_s_r;
    assign rd_nacked = rise_ev && state_r == LMISL_RDAT && rbit_r == ACK_SLOT && sda_s_r;
    // a full buffer refuses the byte with no acknowledge rather than losing it
    assign push_valid = byte_ev && state_r == LMISL_DATA && push_ready;

    always_ff @(posedge i_mclk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            state_r <= LMISL_IDLE;
            o_rd_addr <= 8'h00;
            ack_pend_r <= 1'h0;
        end
        else if (stop_ev)
        begin
            state_r <= LMISL_IDLE;
            ack_pend_r <= 1'h0;
        end
        else if (start_ev)
        begin
            state_r <= LMISL_ADDR;
            ack_pend_r <= 1'h0;
        end
        else
        begin
            if (fall_ev && ack_pend_r)
            begin
                ack_pend_r <= 1'h0;
            end
            if (rd_acked)
            begin
                o_rd_addr <= o_rd_addr + 8'h01;
            end
            if (rd_nacked)
            begin
                state_r <= LMISL_IGNORE;
            end
            if (byte_ev)
            begin
                case (state_r)
                    LMISL_ADDR:
                    begin
                        if (addr_match)
                        begin
                            ack_pend_r <= 1'h1;
                            state_r <= (lk_byte_r[0] == DIR_READ) ? LMISL_RDAT : LMISL_REG;
                        end
                        else
                        begin
                            state_r <= LMISL_IGNORE;
                        end
                    end
                    LMISL_REG:
                    begin
                        o_rd_addr <= lk_byte_r;
                        ack_pend_r <= 1'h1;
                        state_r <= LMISL_DATA;
                    end
                    LMISL_DATA:
                    begin
                        if (push_ready)
                        begin
                            ack_pend_r <= 1'h1;
                            o_rd_addr <= o_rd_addr + 8'h01;
                        end
                        else
                        begin
                            state_r <= LMISL_IGNORE;
                        end
                    end
                    default:
                    begin
                        state_r <= state_r;
                    end
                endcase
            end
        end
    end

    always_ff @(posedge i_mclk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            o_busy <= 1'h0;
        end
        else
        begin
            o_busy <= state_r != LMISL_IDLE;
        end
    end

    // ************************************************************
    // data line drive: acknowledge and read bits, changed after clock falls
    // ************************************************************
    logic ack_drv_r;
    logic [7:0] rd_sh_r;

    always_ff @(posedge i_mclk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            o_sda_oe <= 1'h0;
            o_sda_out <= 1'h0;
            ack_drv_r <= 1'h0;
            rbit_r <= 4'h0;
            rd_sh_r <= 8'h00;
        end
        else if (start_ev || stop_ev)
        begin
            o_sda_oe <= 1'h0;
            ack_drv_r <= 1'h0;
            rbit_r <= 4'h0;
        end
        else if (fall_ev)
        begin
            if (ack_drv_r)
            begin
                ack_drv_r <= 1'h0;
                if (state_r == LMISL_RDAT)
                begin
                    rd_sh_r <= i_rd_data;
                    o_sda_oe <= ~i_rd_data[7];
                    rbit_r <= 4'h0;
                end
                else
                begin
                    o_sda_oe <= 1'h0;
                end
            end
            else if (ack_pend_r)
            begin
                ack_drv_r <= 1'h1;
                o_sda_oe <= 1'h1;
            end
            else if (state_r == LMISL_RDAT)
            begin
                if (rbit_r < LAST_DATA_BIT)
                begin
                    rbit_r <= rbit_r + 4'h1;
                    rd_sh_r <= {rd_sh_r[6:0], 1'h0};
                    o_sda_oe <= ~rd_sh_r[6];
                end
                else if (rbit_r == LAST_DATA_BIT)
                begin
                    rbit_r <= ACK_SLOT;
                    o_sda_oe <= 1'h0;
                end
                else
                begin
                    rd_sh_r <= i_rd_data;
                    o_sda_oe <= ~i_rd_data[7];
                    rbit_r <= 4'h0;
                end
            end
            else
            begin
                o_sda_oe <= 1'h0;
            end
        end
    end

    // ************************************************************
    // two-entry write buffer, output stage plus skid entry
    // ************************************************************
    lmisl_wr_s skid_r;
    logic skid_valid_r;
    logic pop;
    lmisl_wr_s push_word;

    assign push_ready = ~skid_valid_r;
    assign pop = o_wr_valid & i_wr_ready;
    assign push_word = '{addr: o_rd_addr, data: lk_byte_r};

    always_ff @(posedge i_mclk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            o_wr_valid <= 1'h0;
            o_wr <= '0;
            skid_r <= '0;
            skid_valid_r <= 1'h0;
        end
        else if (skid_valid_r)
        begin
            if (pop)
            begin
                o_wr <= skid_r;
                skid_valid_r <= 1'h0;
            end
        end
        else if (push_valid)
        begin
            if (!o_wr_valid || pop)
            begin
                o_wr <= push_word;
                o_wr_valid <= 1'h1;
            end
            else
            begin
                skid_r <= push_word;
                skid_valid_r <= 1'h1;
            end
        end
        else if (pop)
        begin
            o_wr_valid <= 1'h0;
        end
    end

endmodule // lmisl_slave

`default_nettype wire

// ==== tb/lmisl_slave_chk_assertions.sv ====
// checker for the two-wire slave port: framing, acknowledge, write stream
// assumes it is bound to lmisl_slave and sees only its ports
`timescale 1ns/1ns
`default_nettype none
module lmisl_slave_chk
(
    input wire logic i_mclk,
    input wire logic i_rst_n,
    input wire logic i_scl_clk,
    input wire logic i_sda,
    input wire logic o_sda_out,
    input wire logic o_sda_oe,
    input wire logic o_wr_valid,
    input wire lmisl_pkg::lmisl_wr_s o_wr,
    input wire logic i_wr_ready,
    input wire logic [7:0] o_rd_addr,
    input wire logic o_busy
);
    import lmisl_pkg::*;
    // ************************************************************
    // raw wire samples, no synchroniser delay, so the design lags them
    // ************************************************************
    logic scl_r, sda_r, start_seen, stop_seen;
    logic [3:0] since_stop_r;
    assign start_seen = scl_r & i_scl_clk & sda_r & ~i_sda;
    assign stop_seen = scl_r & i_scl_clk & ~sda_r & i_sda;
    always_ff @(posedge i_mclk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            scl_r <= 1'h0;
            sda_r <= 1'h0;
            since_stop_r <= 4'hF;
        end
        else
        begin
            scl_r <= i_scl_clk;
            sda_r <= i_sda;
            if (stop_seen)
                since_stop_r <= 4'h0;
            else if (since_stop_r != 4'hF)
                since_stop_r <= since_stop_r + 4'h1;
        end
    end
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (!i_rst_n);
    property p_out_zero;
        o_sda_out == 1'h0;
    endproperty
    a_out_zero: assert property (p_out_zero) else $error("data driven high");
    property p_oe_low;
        $changed(o_sda_oe) |-> !i_scl_clk;
    endproperty
    a_oe_low: assert property (p_oe_low) else $error("data moved, clock high");
    property p_oe_min;
        $rose(o_sda_oe) |-> o_sda_oe[*8];
    endproperty
    a_oe_min: assert property (p_oe_min) else $error("acknowledge too short");
    property p_wr_hold;
        o_wr_valid && !i_wr_ready |=> o_wr_valid && $stable(o_wr);
    endproperty
    a_wr_hold: assert property (p_wr_hold) else $error("word lost in stall");
    property p_ptr_inc;
        $rose(o_wr_valid) |-> ##[0:2] (o_rd_addr == o_wr.addr + 8'h01);
    endproperty
    a_ptr_inc: assert property (p_ptr_inc) else $error("pointer not advanced");
    property p_idle_quiet;
        !o_busy |-> !o_sda_oe;
    endproperty
    a_idle_quiet: assert property (p_idle_quiet) else $error("idle line pulled");
    property p_start_busy;
        start_seen |-> ##[1:10] o_busy;
    endproperty
    a_start_busy: assert property (p_start_busy) else $error("start missed");
    property p_stop_idle;
        stop_seen |-> ##[1:10] (!o_busy && !o_sda_oe);
    endproperty
    a_stop_idle: assert property (p_stop_idle) else $error("stop missed");
    property p_busy_fall;
        $fell(o_busy) |-> since_stop_r < 4'hA;
    endproperty
    a_busy_fall: assert property (p_busy_fall) else $error("frame closed early");
    c_ack: cover property ($rose(o_sda_oe));
    c_stall: cover property (o_wr_valid && !i_wr_ready);
    c_stop: cover property (stop_seen ##[1:10] !o_busy);
endmodule // lmisl_slave_chk
bind lmisl_slave lmisl_slave_chk u_chk
(
    .i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_scl_clk(i_scl_clk), .i_sda(i_sda),
    .o_sda_out(o_sda_out), .o_sda_oe(o_sda_oe), .o_wr_valid(o_wr_valid),
    .o_wr(o_wr), .i_wr_ready(i_wr_ready), .o_rd_addr(o_rd_addr), .o_busy(o_busy)
);
`default_nettype wire

// ==== tb/lmisl_host.sv ====
// bus master model: owns the serial clock, pulls the data wire low
// assumes the bench resolves the wire with a pull-up and feeds it back
`timescale 1ns/1ns
`default_nettype none
module lmisl_host
(
    output logic o_scl,
    output logic o_pull,
    input wire logic i_sda
);
    // extra low time, so the slave also meets a slow master
    int gap = 0;
    initial o_scl = 1'h1; // clock stands high between frames
    initial o_pull = 1'h0; // released line rests high
    // data moves 10 ns into the low phase, never while the clock is high
    task automatic bit_io(input logic b, output logic s);
        #10 o_pull = ~b;
        #(53 + gap) o_scl = 1'h1; // period 125 ns, still many logic cycles per phase
        #31 s = i_sda; // sampled mid-high
        #31 o_scl = 1'h0;
    endtask
    task automatic start();
        #10 o_pull = 1'h0;
        #53 o_scl = 1'h1;
        #62 o_pull = 1'h1; // falling data, clock high
        #62 o_scl = 1'h0;
    endtask
    task automatic stop();
        #10 o_pull = 1'h1;
        #53 o_scl = 1'h1;
        #62 o_pull = 1'h0; // rising data, clock high
        #200;
    endtask
    task automatic wbyte(input logic [7:0] b, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--)
            bit_io(b[i], s); // msb first
        bit_io(1'h1, s); // line let go for the slave
        ack = ~s;
    endtask
    task automatic rbyte(output logic [7:0] b, input logic mack);
        logic s;
        for (int i = 7; i >= 0; i--)
            bit_io(1'h1, b[i]);
        bit_io(~mack, s);
    endtask
endmodule // lmisl_host
`default_nettype wire

// ==== tb/led_matrix_i2c_slave_write_port_tb.sv ====
// self-checking bench for the two-wire slave port with a master model
// assumes the wire has a pull-up and the sink takes words when ready
`timescale 1ns/1ns
`default_nettype none
module led_matrix_i2c_slave_write_port_tb;
    import lmisl_pkg::*;
    logic i_mclk, i_rst_n, scl, pull, sda, strap, oe, sda_o, wv, busy, ack;
    logic ready;
    logic [1:0] sel;
    logic [7:0] rd_addr, got;
    logic [7:0] rd_data = 8'h00;
    lmisl_wr_s wr;
    lmisl_wr_s q[$];
    int err_total = 0;
    int tests_run = 0;
    // strap select, expected ack, address byte, register, data
    logic [26:0] rows [0:6] = '{
        {2'h0, 1'h1, 8'hE8, 8'h10, 8'hA5}, {2'h0, 1'h0, 8'hEA, 8'h20, 8'h3C},
        {2'h0, 1'h0, 8'hF8, 8'h20, 8'h3C}, {2'h1, 1'h1, 8'hEE, 8'hFF, 8'h01},
        {2'h2, 1'h1, 8'hEA, 8'h40, 8'h5A}, {2'h3, 1'h1, 8'hEC, 8'h41, 8'hC3},
        {2'h3, 1'h0, 8'hE8, 8'h42, 8'h66}};
    assign sda = ~(oe | pull); // open drain with pull-up
    assign strap = sel[1] ? (sel[0] ? sda : scl) : sel[0]; // gnd vcc clock data
    lmisl_host u_host (.o_scl(scl), .o_pull(pull), .i_sda(sda));
    lmisl_slave DUT
    (
        .i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_scl_clk(scl), .i_sda(sda),
        .o_sda_out(sda_o), .o_sda_oe(oe), .i_strap(strap), .o_wr_valid(wv),
        .o_wr(wr), .i_wr_ready(ready), .o_rd_addr(rd_addr), .i_rd_data(rd_data),
        .o_busy(busy)
    );
    initial
    begin
        i_mclk = 1'h0;
        forever #4 i_mclk = ~i_mclk;
    end
    always @(negedge i_mclk) rd_data <= rd_addr ^ 8'h5A;
    always @(posedge i_mclk) if (wv === 1'h1 && ready === 1'h1) q.push_back(wr);
    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            err_total++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic complete_run();
        $display("checks %0d mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task automatic send(input logic [7:0] b, input logic exp, input string name);
        u_host.wbyte(b, ack);
        check(name, {15'h0, ack}, {15'h0, exp});
    endtask
    task automatic wait_idle();
        int k;
        // realign to the falling edge, the host tasks end off the logic clock
        @(negedge i_mclk);
        for (k = 0; k < 40 && busy !== 1'h0; k++)
            @(negedge i_mclk);
        if (k == 40)
        begin
            err_total++;
            complete_run();
        end
    endtask
    initial
    begin
        #400000;
        err_total++;
        complete_run();
    end
    initial
    begin
        i_rst_n = 1'h0;
        ready = 1'h1;
        sel = 2'h0;
        repeat (10) @(negedge i_mclk);
        check("reset", {wv, busy, oe, sda_o, rd_addr, 4'h0}, 16'h0000);
        check("reset_word", wr, 16'h0000);
        i_rst_n = 1'h1;
        for (int r = 0; r < 7; r++)
        begin
            sel = rows[r][26:25];
            repeat (30) @(negedge i_mclk);
            q.delete();
            u_host.start();
            send(rows[r][23:16], rows[r][24], "addr_ack");
            send(rows[r][15:8], rows[r][24], "reg_ack");
            send(rows[r][7:0], rows[r][24], "data_ack");
            u_host.stop();
            wait_idle();
            check("words", 16'(q.size()), {15'h0, rows[r][24]});
            if (rows[r][24])
            begin
                check("word", q[0], rows[r][15:0]);
                check("pointer", {8'h00, rd_addr}, {8'h00, rows[r][15:8] + 8'h01});
            end
        end
        // sink stalls with a slow master: two words fit, the third is refused
        sel = 2'h0;
        ready = 1'h0;
        u_host.gap = 200;
        repeat (30) @(negedge i_mclk);
        u_host.start();
        send(8'hE8, 1'h1, "addr_ack");
        send(8'h30, 1'h1, "reg_ack");
        send(8'h11, 1'h1, "data_ack");
        send(8'h22, 1'h1, "data_ack");
        send(8'h33, 1'h0, "full_nack");
        u_host.stop();
        wait_idle();
        u_host.gap = 0;
        check("pointer", {8'h00, rd_addr}, 16'h0032);
        check("held", {15'h0, wv}, 16'h0001);
        q.delete();
        ready = 1'h1;
        repeat (4) @(negedge i_mclk);
        check("words", 16'(q.size()), 16'h0002);
        check("word", q[0], 16'h3011);
        check("word", q[1], 16'h3122);
        check("drained", {15'h0, wv}, 16'h0000);
        // pointer set by a write, then a repeated start turns the bus round
        u_host.start();
        send(8'hE8, 1'h1, "addr_ack");
        send(8'h50, 1'h1, "reg_ack");
        u_host.start();
        send(8'hE9, 1'h1, "read_ack");
        u_host.rbyte(got, 1'h1);
        check("read0", {8'h00, got}, 16'h000A);
        u_host.rbyte(got, 1'h0);
        check("read1", {8'h00, got}, 16'h000B);
        u_host.stop();
        wait_idle();
        // reset in mid-frame with a word still held
        ready = 1'h0;
        u_host.start();
        send(8'hE8, 1'h1, "addr_ack");
        send(8'h60, 1'h1, "reg_ack");
        send(8'h77, 1'h1, "data_ack");
        i_rst_n = 1'h0;
        @(negedge i_mclk);
        check("reset_mid", {wv, busy, oe, sda_o, rd_addr, 4'h0}, 16'h0000);
        u_host.stop();
        @(negedge i_mclk);
        i_rst_n = 1'h1;
        ready = 1'h1;
        repeat (20) @(negedge i_mclk);
        check("reset_idle", {15'h0, busy}, 16'h0000);
        complete_run();
    end
endmodule // led_matrix_i2c_slave_write_port_tb
`default_nettype wire
